// >>> shared/mtsp_defines.vh
// Behaviour
// R1: Media pipeline runs only while selected; never concurrently with the 3D pipeline.
// R2: Pipeline switches only by the pipeline choice command, within the same context.
// R3: Front end takes work, writes payload to return buffer, hands thread to spawner.
// R4: Only the spawner issues spawn requests: root threads and child threads.
// R5: Front end writes return buffer only; spawner has no buffer port.
// R6: With constants enabled, front end forwards the constant buffer handle to spawner.
// R7: Spawner answers shared-function messages with its own function id only.
// R8: Each root thread gets at most one return-buffer handle.
// R9: The payload handle is reused as the root thread's return handle.
// R10: Root constants are loaded after header register zero, before payload.
// R11: Child constants are inserted after the parent header; handles split in two.
// R12: Threads end by sending a termination message to the spawner.
// R13: Indirect work data is fetched through the vertex cache port.
// R14: Generic mode and root, child, synchronized and persistent threads are supported; the code implements root and child threads only.
// R15: Decode-specific modes are absent; such commands are refused.
// R16: Each work item builds control with descriptor pointer and payload.
// R17: All transfers use valid/ready handshakes; nothing is lost under backpressure.
`ifndef MTSP_DEFINES_VH
`define MTSP_DEFINES_VH
`define MTSP_ADDR_CTRL 8'h00
`define MTSP_ADDR_STAT 8'h04
`define MTSP_ADDR_CBUF 8'h08
`define MTSP_ADDR_ROOTS 8'h0c
`define MTSP_ADDR_ENDS 8'h10
`define MTSP_CTRL_CONST 0
`define MTSP_CTRL_MODE_LO 1
`define MTSP_CTRL_MODE_HI 2
`define MTSP_OP_SELECT 4'h1
`define MTSP_OP_WORK 4'h2
`define MTSP_OP_MODE 4'h3
`define MTSP_MODE_GENERIC 2'h0
`define MTSP_SEL_3D 1'b0
`define MTSP_SEL_MEDIA 1'b1
`define MTSP_MSG_SPAWN 2'h1
`define MTSP_MSG_END 2'h2
`define MTSP_SF_ID 4'h7
`define MTSP_RESP_OKAY 2'h0
`define MTSP_RESP_SLVERR 2'h2
`endif

// >>> rtl/mtsp_hold.v
module mtsp_hold #(
  parameter W = 32
) (
  // Clock and reset
  input wire ref_clk,
  input wire rst_b,
  // Write side
  input wire wr_en,
  input wire [W-1:0] wr_data,
  // Read side
  output reg [W-1:0] rd_data
);
  // Single-word store; read data registered
  reg [W-1:0] mem_r;
  always @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      mem_r <= {W{1'b0}};
      rd_data <= {W{1'b0}};
    end else begin
      if (wr_en) begin
        mem_r <= wr_data;
      end
      rd_data <= mem_r;
    end
  end
endmodule

// >>> rtl/mtsp_top.v
// The register offsets and the AXI4-Lite register port were chosen for this implementation.
`include "mtsp_defines.vh"
module mtsp_top #(
  parameter HW = 16,
  parameter DW = 32
) (
  // Clock and reset
  input wire ref_clk,
  input wire rst_b,
  // AXI4-Lite slave
  input wire [7:0] s_awaddr,
  input wire s_awvalid,
  output reg s_awready,
  input wire [31:0] s_wdata,
  input wire [3:0] s_wstrb,
  input wire s_wvalid,
  output reg s_wready,
  output reg [1:0] s_bresp,
  output reg s_bvalid,
  input wire s_bready,
  input wire [7:0] s_araddr,
  input wire s_arvalid,
  output reg s_arready,
  output reg [31:0] s_rdata,
  output reg [1:0] s_rresp,
  output reg s_rvalid,
  input wire s_rready,
  // Command streamer
  input wire cmd_valid,
  output reg cmd_ready,
  input wire [3:0] cmd_op,
  input wire [DW-1:0] cmd_data,
  input wire [HW-1:0] cmd_desc,
  // Return buffer write port
  output reg urb_wvalid,
  input wire urb_wready,
  output reg [HW-1:0] urb_whandle,
  output reg [DW-1:0] urb_wdata,
  // Indirect fetch through vertex cache
  output reg vc_req_valid,
  input wire vc_req_ready,
  output reg [DW-1:0] vc_req_addr,
  // Messages from threads
  input wire msg_valid,
  output reg msg_ready,
  input wire [3:0] msg_sfid,
  input wire [1:0] msg_kind,
  input wire [HW-1:0] msg_handle,
  input wire [HW-1:0] msg_desc,
  // Spawn requests to dispatcher
  output reg spn_valid,
  input wire spn_ready,
  output reg spn_child,
  output reg [HW-1:0] spn_desc,
  output reg [HW-1:0] spn_handle,
  output reg [HW-1:0] spn_const,
  output reg spn_const_en,
  output reg [1:0] spn_order,
  // Pipeline status
  output reg media_active,
  output reg pipe3d_active
);
  localparam S_IDLE = 2'd0;
  localparam S_URB = 2'd1;
  localparam S_FETCH = 2'd2;
  localparam S_HAND = 2'd3;

  reg [2:0] ctrl_r;
  reg [HW-1:0] cbuf_r;
  reg [15:0] roots_r;
  reg [15:0] ends_r;
  reg [15:0] refused_r;
  reg [1:0] st_r;
  reg [HW-1:0] next_handle_r;
  reg [HW-1:0] desc_r;
  reg [HW-1:0] handle_r;
  reg hand_v_r;
  reg [HW-1:0] hand_desc_r;
  reg [HW-1:0] hand_handle_r;
  reg aw_hold_r;
  reg w_hold_r;
  reg [7:0] aw_addr_r;
  reg [31:0] w_data_r;
  reg w_strb0_r;
  wire [DW-1:0] last_payload;

  // Last payload word kept for software inspection
  mtsp_hold #(.W(DW)) u_hold (
    .ref_clk(ref_clk),
    .rst_b(rst_b),
    .wr_en(urb_wvalid & urb_wready),
    .wr_data(urb_wdata),
    .rd_data(last_payload)
  );

  function is_mapped;
    input [7:0] a;
    begin
      if (a == `MTSP_ADDR_CTRL) begin
        is_mapped = 1'b1;
      end else if (a == `MTSP_ADDR_STAT || a == `MTSP_ADDR_CBUF) begin
        is_mapped = 1'b1;
      end else if (a == `MTSP_ADDR_ROOTS || a == `MTSP_ADDR_ENDS) begin
        is_mapped = 1'b1;
      end else begin
        is_mapped = 1'b0;
      end
    end
  endfunction

  // AXI4-Lite write: address and data taken in either order
  wire aw_have = aw_hold_r | (s_awvalid & s_awready);
  wire w_have = w_hold_r | (s_wvalid & s_wready);
  wire [7:0] aw_cur = aw_hold_r ? aw_addr_r : s_awaddr;
  wire [31:0] w_cur = w_hold_r ? w_data_r : s_wdata;
  // Strobe travels with its data, which may be taken before the address
  wire w_strb0_cur = w_hold_r ? w_strb0_r : s_wstrb[0];
  wire wr_fire = aw_have & w_have & ~s_bvalid;
  always @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      s_awready <= 1'b1;
      s_wready <= 1'b1;
      s_bvalid <= 1'b0;
      s_bresp <= `MTSP_RESP_OKAY;
      aw_hold_r <= 1'b0;
      w_hold_r <= 1'b0;
      aw_addr_r <= 8'h00;
      w_data_r <= 32'h00000000;
      w_strb0_r <= 1'b0;
      ctrl_r <= 3'h0;
      cbuf_r <= {HW{1'b0}};
    end else begin
      if (s_awvalid & s_awready) begin
        aw_addr_r <= s_awaddr;
      end
      if (s_wvalid & s_wready) begin
        w_data_r <= s_wdata;
        w_strb0_r <= s_wstrb[0];
      end
      if (wr_fire) begin
        aw_hold_r <= 1'b0;
        w_hold_r <= 1'b0;
        s_awready <= 1'b0;
        s_wready <= 1'b0;
        s_bvalid <= 1'b1;
        s_bresp <= is_mapped(aw_cur) ? `MTSP_RESP_OKAY : `MTSP_RESP_SLVERR;
        if (aw_cur == `MTSP_ADDR_CTRL && w_strb0_cur) begin
          ctrl_r <= w_cur[2:0];
        end else if (aw_cur == `MTSP_ADDR_CBUF) begin
          cbuf_r <= w_cur[HW-1:0];
        end
      end else begin
        if (s_awvalid & s_awready) begin
          aw_hold_r <= 1'b1;
          s_awready <= 1'b0;
        end
        if (s_wvalid & s_wready) begin
          w_hold_r <= 1'b1;
          s_wready <= 1'b0;
        end
      end
      if (s_bvalid & s_bready) begin
        s_bvalid <= 1'b0;
        s_awready <= 1'b1;
        s_wready <= 1'b1;
      end
    end
  end

  // AXI4-Lite read
  always @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      s_arready <= 1'b1;
      s_rvalid <= 1'b0;
      s_rdata <= 32'h00000000;
      s_rresp <= `MTSP_RESP_OKAY;
    end else begin
      if (s_arvalid & s_arready) begin
        s_arready <= 1'b0;
        s_rvalid <= 1'b1;
        s_rresp <= is_mapped(s_araddr) ? `MTSP_RESP_OKAY : `MTSP_RESP_SLVERR;
        if (s_araddr == `MTSP_ADDR_CTRL) begin
          s_rdata <= {29'h0, ctrl_r};
        end else if (s_araddr == `MTSP_ADDR_STAT) begin
          s_rdata <= {refused_r, 13'h0, media_active, st_r};
        end else if (s_araddr == `MTSP_ADDR_CBUF) begin
          s_rdata <= {{(32-HW){1'b0}}, cbuf_r};
        end else if (s_araddr == `MTSP_ADDR_ROOTS) begin
          s_rdata <= {16'h0, roots_r};
        end else if (s_araddr == `MTSP_ADDR_ENDS) begin
          s_rdata <= {ends_r, 16'h0} | {16'h0, last_payload[15:0]};
        end else begin
          s_rdata <= 32'h00000000;
        end
      end else if (s_rvalid & s_rready) begin
        s_rvalid <= 1'b0;
        s_arready <= 1'b1;
      end
    end
  end

  // Front end: command intake, payload write, fetch, handoff
  wire const_on = ctrl_r[`MTSP_CTRL_CONST];
  wire mode_ok = (ctrl_r[2:1] == `MTSP_MODE_GENERIC);
  wire cmd_take = cmd_valid & cmd_ready;
  wire busy = (st_r != S_IDLE) | hand_v_r | spn_valid;
  always @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      st_r <= S_IDLE;
      cmd_ready <= 1'b0;
      media_active <= 1'b0;
      pipe3d_active <= 1'b1;
      urb_wvalid <= 1'b0;
      urb_whandle <= {HW{1'b0}};
      urb_wdata <= {DW{1'b0}};
      vc_req_valid <= 1'b0;
      vc_req_addr <= {DW{1'b0}};
      next_handle_r <= {HW{1'b0}};
      desc_r <= {HW{1'b0}};
      handle_r <= {HW{1'b0}};
      hand_v_r <= 1'b0;
      hand_desc_r <= {HW{1'b0}};
      hand_handle_r <= {HW{1'b0}};
      roots_r <= 16'h0000;
      refused_r <= 16'h0000;
    end else begin
      // No new payload while a root waits, so its handle is the last one written
      cmd_ready <= (st_r == S_IDLE) & ~hand_v_r & ~cmd_take; // see R17
      case (st_r)
        S_IDLE: begin
          if (cmd_take) begin
            if (cmd_op == `MTSP_OP_SELECT) begin
              // Switch only once idle, in-context; one pipeline at a time
              if (!busy) begin // see R2
                media_active <= cmd_data[0] == `MTSP_SEL_MEDIA; // see R1
                pipe3d_active <= cmd_data[0] == `MTSP_SEL_3D; // see R1
              end else begin
                refused_r <= refused_r + 16'h0001;
              end
            end else if (cmd_op == `MTSP_OP_WORK && media_active && mode_ok) begin
              // Payload handle doubles as the single return handle
              desc_r <= cmd_desc; // see R16
              handle_r <= next_handle_r; // see R8
              next_handle_r <= next_handle_r + {{(HW-1){1'b0}}, 1'b1};
              urb_whandle <= next_handle_r; // see R9
              urb_wdata <= cmd_data; // see R3
              urb_wvalid <= 1'b1; // see R5
              st_r <= S_URB;
            end else begin
              // Decode-specific modes and work while 3D is active are dropped
              refused_r <= refused_r + 16'h0001; // see R15
            end
          end
        end
        S_URB: begin
          if (urb_wready) begin // see R17
            urb_wvalid <= 1'b0;
            vc_req_valid <= 1'b1; // see R13
            vc_req_addr <= urb_wdata;
            st_r <= S_FETCH;
          end
        end
        S_FETCH: begin
          if (vc_req_ready) begin
            vc_req_valid <= 1'b0;
            st_r <= S_HAND;
          end
        end
        default: begin
          if (!hand_v_r) begin
            hand_v_r <= 1'b1; // see R3
            hand_desc_r <= desc_r;
            hand_handle_r <= handle_r;
            roots_r <= roots_r + 16'h0001; // see R14
            st_r <= S_IDLE;
          end
        end
      endcase
      if (hand_v_r && !spn_valid) begin
        hand_v_r <= 1'b0;
      end
    end
  end

  // Spawner: sole source of spawn requests; root handoff has priority
  wire msg_mine = msg_sfid == `MTSP_SF_ID;
  wire child_take = msg_valid & msg_ready & msg_mine & (msg_kind == `MTSP_MSG_SPAWN);
  always @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      msg_ready <= 1'b0;
      spn_valid <= 1'b0;
      spn_child <= 1'b0;
      spn_desc <= {HW{1'b0}};
      spn_handle <= {HW{1'b0}};
      spn_const <= {HW{1'b0}};
      spn_const_en <= 1'b0;
      spn_order <= 2'h0;
      ends_r <= 16'h0000;
    end else begin
      // Messages with a foreign function id are ignored, never snooped
      // Also closed one cycle ahead of a root handoff, so a taken child is never lost
      msg_ready <= ~spn_valid & ~hand_v_r & (st_r != S_HAND) & ~(msg_valid & msg_ready); // see R7
      if (msg_valid && msg_ready && msg_mine && msg_kind == `MTSP_MSG_END) begin
        ends_r <= ends_r + 16'h0001; // see R12
      end
      if (spn_valid) begin
        if (spn_ready) begin // see R17
          spn_valid <= 1'b0;
        end
      end else if (hand_v_r) begin
        spn_valid <= 1'b1; // see R4
        spn_child <= 1'b0;
        spn_desc <= hand_desc_r;
        spn_handle <= hand_handle_r;
        spn_const <= cbuf_r; // see R6
        spn_const_en <= const_on;
        spn_order <= const_on ? 2'h1 : 2'h0; // see R10
      end else if (child_take) begin
        spn_valid <= 1'b1; // see R4
        spn_child <= 1'b1;
        spn_desc <= msg_desc;
        spn_handle <= msg_handle;
        spn_const <= cbuf_r;
        spn_const_en <= const_on;
        spn_order <= const_on ? 2'h2 : 2'h0; // see R11
      end
    end
  end
endmodule

// >>> test/mtsp_top_asserts.sv
module mtsp_top_asserts #(
  parameter HW = 16,
  parameter DW = 32
) (
  // Clock and reset
  input wire ref_clk,
  input wire rst_b,
  // Handshakes
  input wire cmd_valid,
  input wire cmd_ready,
  input wire urb_wvalid,
  input wire urb_wready,
  input wire vc_req_valid,
  input wire vc_req_ready,
  input wire spn_valid,
  input wire spn_ready,
  // Payload and status
  input wire [HW-1:0] urb_whandle,
  input wire [DW-1:0] urb_wdata,
  input wire spn_child,
  input wire spn_const_en,
  input wire [1:0] spn_order,
  input wire [HW-1:0] spn_desc,
  input wire [HW-1:0] spn_handle,
  input wire media_active,
  input wire pipe3d_active
);
  reg [HW-1:0] last_h_r;
  // Handle of the payload most recently taken by the return buffer
  always @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      last_h_r <= {HW{1'b0}};
    end else if (urb_wvalid && urb_wready) begin
      last_h_r <= urb_whandle;
    end
  end
  default clocking @(posedge ref_clk); endclocking
  default disable iff (!rst_b);
  a_one_pipe: assert property (media_active != pipe3d_active)
    else $error("pipelines not exclusive");
  a_urb_media: assert property (urb_wvalid |-> media_active)
    else $error("payload written outside media");
  a_cmd_drop: assert property (cmd_valid && cmd_ready |=> !cmd_ready)
    else $error("ready stayed after take");
  a_urb_hold: assert property (urb_wvalid && !urb_wready |=> urb_wvalid &&
    $stable(urb_whandle) && $stable(urb_wdata)) else $error("payload write not held");
  a_vc_hold: assert property (vc_req_valid && !vc_req_ready |=> vc_req_valid)
    else $error("fetch request dropped");
  a_spn_hold: assert property (spn_valid && !spn_ready |=> spn_valid &&
    $stable(spn_handle) && $stable(spn_desc)) else $error("spawn not held");
  a_root_handle: assert property ($rose(spn_valid) && !spn_child |->
    spn_handle == last_h_r) else $error("root handle differs");
  a_spawn_order: assert property (spn_valid |-> spn_order ==
    (spn_const_en ? (spn_child ? 2'h2 : 2'h1) : 2'h0)) else $error("bad load order");
endmodule

bind mtsp_top mtsp_top_asserts #(.HW(HW), .DW(DW)) i_chk (.ref_clk, .rst_b, .cmd_valid,
  .cmd_ready, .urb_wvalid, .urb_wready, .vc_req_valid, .vc_req_ready, .spn_valid,
  .spn_ready, .urb_whandle, .urb_wdata, .spn_child, .spn_const_en, .spn_order, .spn_desc,
  .spn_handle, .media_active, .pipe3d_active);

// >>> test/mtsp_far_model.sv
module mtsp_far_model (
  // Clock and reset
  input wire ref_clk,
  input wire rst_b,
  // Requests from the pipeline
  input wire urb_wvalid,
  input wire vc_req_valid,
  input wire spn_valid,
  // Acceptance
  output logic urb_wready,
  output logic vc_req_ready,
  output logic spn_ready
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [2:0] tick_r;
  // Readies drop on a fixed pattern so that every request channel meets backpressure
  always @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      tick_r <= 3'h0;
      {urb_wready, vc_req_ready, spn_ready} <= 3'h0;
    end else begin
      tick_r <= tick_r + 3'h1;
      urb_wready <= tick_r[0];
      vc_req_ready <= &tick_r[1:0];
      spn_ready <= tick_r[2];
    end
  end
endmodule

// >>> test/tb.sv
`include "mtsp_defines.vh"
module tb;
  timeunit 1ns;
  timeprecision 1ps;
  logic ref_clk, rst_b, s_awvalid, s_awready, s_wvalid, s_wready, s_bvalid, s_bready;
  logic s_arvalid, s_arready, s_rvalid, s_rready, cmd_valid, cmd_ready, msg_valid, msg_ready;
  logic urb_wvalid, urb_wready, vc_req_valid, vc_req_ready, spn_valid, spn_ready;
  logic spn_child, spn_const_en, media_active, pipe3d_active, sp_ch, sp_e;
  logic [7:0] s_awaddr, s_araddr;
  logic [3:0] s_wstrb, cmd_op, msg_sfid;
  logic [1:0] s_bresp, s_rresp, msg_kind, spn_order, sp_o, rsp;
  logic [31:0] s_wdata, s_rdata, cmd_data, urb_wdata, vc_req_addr, rd, u_d, va;
  logic [15:0] cmd_desc, msg_handle, msg_desc, urb_whandle, spn_desc, spn_handle, spn_const;
  logic [15:0] h_exp, cb, hh, u_h, sp_h, sp_d, sp_c;
  integer seed = 84, err_total = 0, cmp_count = 0, cyc = 0, sp_n = 0, ref_n = 0, roots = 0;
  integer i, n;
  mtsp_top i_dut (.*);
  mtsp_far_model i_far (.*);
  initial begin
    ref_clk = 1'b0;
    forever #12.5 ref_clk = ~ref_clk;
  end
  function automatic [31:0] stat_exp(input [15:0] r, input m);
    stat_exp = {r, 13'h0, m, 2'h0};
  endfunction
  function automatic [1:0] ord_exp(input c, input ch);
    ord_exp = !c ? 2'h0 : (ch ? 2'h2 : 2'h1);
  endfunction
  task report_and_stop;
    $display("compares=%0d mismatches=%0d", cmp_count, err_total);
    if (err_total == 0 && cmp_count > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask
  task chk(input [31:0] got, input [31:0] exp);
    cmp_count = cmp_count + 1;
    if (got !== exp) begin
      err_total = err_total + 1;
      $display("FAIL t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  always @(posedge ref_clk) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      err_total = err_total + 1;
      report_and_stop;
    end
    if (urb_wvalid && urb_wready) {u_h, u_d} <= {urb_whandle, urb_wdata};
    if (vc_req_valid && vc_req_ready) va <= vc_req_addr;
    if (spn_valid && spn_ready) begin
      sp_n <= sp_n + 1;
      {sp_h, sp_d, sp_c, sp_o, sp_ch, sp_e} <= {spn_handle, spn_desc, spn_const, spn_order,
        spn_child, spn_const_en};
    end
  end
  task axw(input [7:0] a, input [31:0] d);
    @(posedge ref_clk);
    {s_awaddr, s_wdata, s_awvalid, s_wvalid, s_bready} <= {a, d, 3'h7};
    do begin
      @(posedge ref_clk);
      if (s_awvalid && s_awready) s_awvalid <= 1'b0;
      if (s_wvalid && s_wready) s_wvalid <= 1'b0;
    end while (s_bvalid !== 1'b1);
    rsp = s_bresp;
    s_bready <= 1'b0;
  endtask
  task axr(input [7:0] a);
    @(posedge ref_clk);
    {s_araddr, s_arvalid, s_rready} <= {a, 2'h3};
    do begin
      @(posedge ref_clk);
      if (s_arvalid && s_arready) s_arvalid <= 1'b0;
    end while (s_rvalid !== 1'b1);
    {rd, rsp} = {s_rdata, s_rresp};
    s_rready <= 1'b0;
  endtask
  task cmd(input [3:0] op, input [31:0] d, input [15:0] ds);
    @(posedge ref_clk);
    {cmd_op, cmd_data, cmd_desc, cmd_valid} <= {op, d, ds, 1'b1};
    do @(posedge ref_clk); while (cmd_ready !== 1'b1);
    cmd_valid <= 1'b0;
  endtask
  task msg(input [3:0] sf, input [1:0] k, input [15:0] h);
    @(posedge ref_clk);
    {msg_sfid, msg_kind, msg_handle, msg_desc, msg_valid} <= {sf, k, h, ~h, 1'b1};
    do @(posedge ref_clk); while (msg_ready !== 1'b1);
    msg_valid <= 1'b0;
  endtask
  task work(input c);
    logic [31:0] d;
    logic [15:0] ds;
    d = $random(seed);
    ds = $random(seed);
    n = sp_n;
    cmd(`MTSP_OP_WORK, d, ds);
    while (sp_n == n) @(posedge ref_clk);
    chk(u_h, h_exp);
    chk(u_d, d);
    chk(va, d);
    chk(sp_e, c);
    chk(sp_h, h_exp);
    chk(sp_d, ds);
    chk(sp_o, ord_exp(c, 1'b0));
    if (c) chk(sp_c, cb);
    h_exp = h_exp + 16'h1;
    roots = roots + 1;
  endtask
  initial begin
    {s_awvalid, s_wvalid, s_bready, s_arvalid, s_rready, cmd_valid, msg_valid} = 7'h0;
    {s_awaddr, s_araddr, s_wdata, cmd_op, cmd_data, cmd_desc} = 100'h0;
    {msg_sfid, msg_kind, msg_handle, msg_desc, h_exp} = 54'h0;
    s_wstrb = 4'hf;
    rst_b = 1'b0;
    repeat (8) @(posedge ref_clk);
    rst_b <= 1'b1;
    repeat (2) @(posedge ref_clk);
    chk(pipe3d_active, 1'b1);
    axr(8'h40);
    chk(rsp, `MTSP_RESP_SLVERR);
    cmd(`MTSP_OP_WORK, $random(seed), 16'h0);
    ref_n = ref_n + 1;
    axr(`MTSP_ADDR_STAT);
    chk(rd & 32'hffff0004, stat_exp(ref_n, 1'b0));
    $display("test idle_refusal done");
    cmd(`MTSP_OP_SELECT, 32'h1, 16'h0);
    repeat (2) @(posedge ref_clk);
    chk(media_active, 1'b1);
    work(1'b0);
    cb = $random(seed);
    axw(`MTSP_ADDR_CBUF, {16'h0, cb});
    axw(`MTSP_ADDR_CTRL, 32'h1);
    chk(rsp, `MTSP_RESP_OKAY);
    for (i = 0; i < 6; i = i + 1) work(1'b1);
    axr(`MTSP_ADDR_ROOTS);
    chk(rd, roots);
    $display("test root_spawn done");
    hh = $random(seed);
    n = sp_n;
    msg(`MTSP_SF_ID, `MTSP_MSG_SPAWN, hh);
    while (sp_n == n) @(posedge ref_clk);
    chk(sp_ch, 1'b1);
    chk({sp_h, sp_d}, {hh, ~hh});
    chk(sp_o, ord_exp(1'b1, 1'b1));
    n = sp_n;
    msg(4'h3, `MTSP_MSG_SPAWN, hh);
    repeat (10) @(posedge ref_clk);
    chk(sp_n, n);
    msg(`MTSP_SF_ID, `MTSP_MSG_END, hh);
    msg(`MTSP_SF_ID, `MTSP_MSG_END, hh);
    axr(`MTSP_ADDR_ENDS);
    chk(rd, {16'h2, u_d[15:0]});
    $display("test child_and_end done");
    for (i = 1; i < 4; i = i + 1) begin
      axw(`MTSP_ADDR_CTRL, i << 1);
      cmd(`MTSP_OP_WORK, 32'h0, 16'h0);
    end
    cmd(4'hf, 32'h0, 16'h0);
    ref_n = ref_n + 4;
    axr(`MTSP_ADDR_STAT);
    chk(rd & 32'hffff0004, stat_exp(ref_n, 1'b1));
    s_wstrb <= 4'h0;
    axw(`MTSP_ADDR_CTRL, 32'h0);
    s_wstrb <= 4'hf;
    axr(`MTSP_ADDR_CTRL);
    chk(rd, 32'h6);
    cmd(`MTSP_OP_SELECT, 32'h0, 16'h0);
    repeat (2) @(posedge ref_clk);
    chk(pipe3d_active, 1'b1);
    $display("test refusal_and_select done");
    report_and_stop;
  end
endmodule
